// ===== verilog/egps_speed_gear.sv
// Purpose: Electronic gear and contact input preset speed selector with soft start
// Assumes: Contact inputs and pulses are synchronous to clock, active high
// Notes: APB slave with zero wait states; speed reference is signed r/min
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

//Operation
// - Scale reference pulses by numerator over denominator
// - Gear terms range 1 to 65535, default 1
// - Bit 2 of function switch enables selection
// - Select inputs pick stop or three speeds
// - Direction input off forward, on reverse
// - Disabled: direction is PI, selects limit current
// - Selection enabled disables pulse blocking input
// - Preset speeds 0 to max, defaults 100/200/300
// - Ramp-up time to 4500 r/min, 0..10000 ms
// - Ramp-down time from max to stop
// - Ramp only in preset mode, not pulses
// - Selection enable changes monitor bits 7, 8
// - Leaving preset while turning ignores pulses until done
// - Select changes recognised within 6 ms
module egps_speed_gear #(
  parameter int unsigned CYCLES_PER_MS = egps_pkg::CYCLES_PER_MS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Contact inputs
  input wire logic directionOrPiSelect,
  input wire logic speedSelectFirst,
  input wire logic speedSelectSecond,
  input wire logic pulseInhibit,
  // Position reference pulses
  input wire logic refPulse,
  input wire logic refPulseDir,
  input wire logic inPosition,
  // Scaled pulses and speed
  output logic gearPulse,
  output logic gearPulseDir,
  output logic signed [15:0] speedRef,
  output logic presetActive,
  // Standard contact meanings
  output logic piSelect,
  output logic fwdCurrentLimit,
  output logic revCurrentLimit,
  output logic positioningDone,
  output logic [15:0] monitorStatusWord
);
  localparam int SEL_BOUND = 2;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] clampMax(input logic [15:0] v, input logic [15:0] lim);
    clampMax = (v > lim) ? lim : v;
  endfunction : clampMax

  function automatic logic [15:0] clampGear(input logic [15:0] v);
    clampGear = (v < egps_pkg::GEAR_MIN) ? egps_pkg::GEAR_MIN : v;
  endfunction : clampGear

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [15:0] gearRatioNumerator_ff;
  logic [15:0] gearRatioDenominator_ff;
  logic [15:0] presetSpeedOne_ff;
  logic [15:0] presetSpeedTwo_ff;
  logic [15:0] presetSpeedThree_ff;
  logic [15:0] rampUpTime_ff;
  logic [15:0] rampDownTime_ff;
  logic [15:0] functionSwitchWord_ff;
  logic wrEn;
  logic setupPhase;
  logic addrHit;
  logic [15:0] wData;

  assign wrEn = psel & penable & pwrite;
  assign setupPhase = psel & ~penable;
  assign wData = pwdata[15:0];

  // Writes land on the access edge; out-of-range values are clamped
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gearRatioNumerator_ff <= egps_pkg::RST_GEAR;
      gearRatioDenominator_ff <= egps_pkg::RST_GEAR;
      presetSpeedOne_ff <= egps_pkg::RST_SPEED_ONE;
      presetSpeedTwo_ff <= egps_pkg::RST_SPEED_TWO;
      presetSpeedThree_ff <= egps_pkg::RST_SPEED_THREE;
      rampUpTime_ff <= egps_pkg::RST_RAMP;
      rampDownTime_ff <= egps_pkg::RST_RAMP;
      functionSwitchWord_ff <= egps_pkg::RST_FUNC_SWITCH;
    end else if (wrEn) begin
      case (paddr)
        egps_pkg::OFS_GEAR_NUM: gearRatioNumerator_ff <= clampGear(wData);
        egps_pkg::OFS_GEAR_DEN: gearRatioDenominator_ff <= clampGear(wData);
        egps_pkg::OFS_SPEED_ONE: presetSpeedOne_ff <= clampMax(wData, egps_pkg::MAX_SPEED_RPM);
        egps_pkg::OFS_SPEED_TWO: presetSpeedTwo_ff <= clampMax(wData, egps_pkg::MAX_SPEED_RPM);
        egps_pkg::OFS_SPEED_THREE: presetSpeedThree_ff <= clampMax(wData, egps_pkg::MAX_SPEED_RPM);
        egps_pkg::OFS_RAMP_UP: rampUpTime_ff <= clampMax(wData, egps_pkg::RAMP_TIME_MAX);
        egps_pkg::OFS_RAMP_DOWN: rampDownTime_ff <= clampMax(wData, egps_pkg::RAMP_TIME_MAX);
        egps_pkg::OFS_FUNC_SWITCH: functionSwitchWord_ff <= wData;
        default: ;
      endcase
    end
  end

  // Address decode for the error answer; the read mux decodes the address on its own
  always_comb begin
    unique case (paddr)
      egps_pkg::OFS_GEAR_NUM, egps_pkg::OFS_GEAR_DEN, egps_pkg::OFS_SPEED_ONE,
      egps_pkg::OFS_SPEED_TWO, egps_pkg::OFS_SPEED_THREE, egps_pkg::OFS_RAMP_UP,
      egps_pkg::OFS_RAMP_DOWN, egps_pkg::OFS_FUNC_SWITCH, egps_pkg::OFS_MONITOR,
      egps_pkg::OFS_SPEED_REF: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (setupPhase && !pwrite) begin
      case (paddr)
        egps_pkg::OFS_GEAR_NUM: prdata <= {16'h0, gearRatioNumerator_ff};
        egps_pkg::OFS_GEAR_DEN: prdata <= {16'h0, gearRatioDenominator_ff};
        egps_pkg::OFS_SPEED_ONE: prdata <= {16'h0, presetSpeedOne_ff};
        egps_pkg::OFS_SPEED_TWO: prdata <= {16'h0, presetSpeedTwo_ff};
        egps_pkg::OFS_SPEED_THREE: prdata <= {16'h0, presetSpeedThree_ff};
        egps_pkg::OFS_RAMP_UP: prdata <= {16'h0, rampUpTime_ff};
        egps_pkg::OFS_RAMP_DOWN: prdata <= {16'h0, rampDownTime_ff};
        egps_pkg::OFS_FUNC_SWITCH: prdata <= {16'h0, functionSwitchWord_ff};
        egps_pkg::OFS_MONITOR: prdata <= {16'h0, monitorStatusWord};
        egps_pkg::OFS_SPEED_REF: prdata <= {16'h0, speedRef};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  // ****************************************************************
  // Contact inputs and mode decode
  // ****************************************************************
  logic selFirst_ff;
  logic selSecond_ff;
  logic dirReverse_ff;
  logic inPosition_ff;
  logic selEnable;
  logic pulseMode;
  logic pulseModePrev_ff;
  logic [15:0] presetMag;
  logic signed [15:0] targetRef;

  // One register stage keeps recognition far inside the allowed delay
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      selFirst_ff <= 1'b0;
      selSecond_ff <= 1'b0;
      dirReverse_ff <= 1'b0;
      inPosition_ff <= 1'b0;
    end else begin
      selFirst_ff <= speedSelectFirst;
      selSecond_ff <= speedSelectSecond;
      dirReverse_ff <= directionOrPiSelect;
      inPosition_ff <= inPosition;
    end
  end

  assign selEnable = functionSwitchWord_ff[egps_pkg::FSW_SPEED_SEL_BIT];
  // Both selects off mean stop, or pulse reference when that bit is set
  assign pulseMode = selEnable
    ? (~selFirst_ff & ~selSecond_ff & functionSwitchWord_ff[egps_pkg::FSW_PULSE_REF_BIT])
    : 1'b1;
  assign presetActive = selEnable & ~pulseMode;

  // Speed table: 01 first, 11 second, 10 third
  always_comb begin
    unique case ({selFirst_ff, selSecond_ff})
      2'b01: presetMag = presetSpeedOne_ff;
      2'b11: presetMag = presetSpeedTwo_ff;
      2'b10: presetMag = presetSpeedThree_ff;
      2'b00: presetMag = 16'h0000;
    endcase
  end

  // Direction input off is forward, on is reverse
  assign targetRef = dirReverse_ff ? -signed'(presetMag) : signed'(presetMag);

  // ****************************************************************
  // Soft start ramp
  // ****************************************************************
  logic signed [15:0] speedRef_ff;
  logic [31:0] rampAcc_ff;
  logic accelMove;
  logic [15:0] rampTime;
  logic [31:0] rampThr;
  logic [32:0] rampSum;

  // Moving away from zero accelerates, toward zero decelerates
  assign accelMove = (speedRef_ff == 16'sh0) ||
    ((speedRef_ff > 16'sh0) && (targetRef > speedRef_ff)) ||
    ((speedRef_ff < 16'sh0) && (targetRef < speedRef_ff));
  assign rampTime = accelMove ? rampUpTime_ff : rampDownTime_ff;
  assign rampThr = 32'(rampTime) * 32'(CYCLES_PER_MS);
  assign rampSum = {1'b0, rampAcc_ff} + {17'h0, egps_pkg::MAX_SPEED_RPM};

  // Each clock adds max speed; one r/min step per threshold gives max/time slope
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      speedRef_ff <= 16'sh0;
      rampAcc_ff <= 32'h0;
    end else if (!presetActive) begin
      speedRef_ff <= 16'sh0;
      rampAcc_ff <= 32'h0;
    end else if (speedRef_ff == targetRef) begin
      rampAcc_ff <= 32'h0;
    end else if (rampTime == 16'h0) begin
      speedRef_ff <= targetRef;
      rampAcc_ff <= 32'h0;
    end else if (rampSum >= {1'b0, rampThr}) begin
      speedRef_ff <= (targetRef > speedRef_ff) ? speedRef_ff + 16'sh1 : speedRef_ff - 16'sh1;
      rampAcc_ff <= 32'(rampSum - {1'b0, rampThr});
    end else begin
      rampAcc_ff <= rampSum[31:0];
    end
  end
  assign speedRef = speedRef_ff;

  // ****************************************************************
  // Pulse path and gear
  // ****************************************************************
  logic pulseBlocked_ff;
  logic setBlock;
  logic gearInPulse;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulseModePrev_ff <= 1'b1;
    end else begin
      pulseModePrev_ff <= pulseMode;
    end
  end

  // Entering pulse mode while still turning arms the block; set beats clear
  assign setBlock = pulseMode & ~pulseModePrev_ff & (speedRef_ff != 16'sh0);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pulseBlocked_ff <= 1'b0;
    end else if (setBlock) begin
      pulseBlocked_ff <= 1'b1;
    end else if (inPosition_ff) begin
      pulseBlocked_ff <= 1'b0;
    end
  end

  // Inhibit input only counts while selection is off
  assign gearInPulse = refPulse & pulseMode & ~pulseBlocked_ff & ~setBlock
    & ~(pulseInhibit & ~selEnable);

  egps_gear_scaler u_gear (
    .clock(clock),
    .rst_n(rst_n),
    .inPulse(gearInPulse),
    .inDir(refPulseDir),
    .numerator(gearRatioNumerator_ff),
    .denominator(gearRatioDenominator_ff),
    .outPulse(gearPulse),
    .outDir(gearPulseDir)
  );

  // ****************************************************************
  // Standard contact outputs and monitor word
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      piSelect <= 1'b0;
      fwdCurrentLimit <= 1'b0;
      revCurrentLimit <= 1'b0;
      positioningDone <= 1'b0;
    end else begin
      piSelect <= ~selEnable & dirReverse_ff;
      fwdCurrentLimit <= ~selEnable & selFirst_ff;
      revCurrentLimit <= ~selEnable & selSecond_ff;
      positioningDone <= inPosition_ff;
    end
  end

  // Bits 7 and 8 show limit requests, or preset active and reverse direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      monitorStatusWord <= 16'h0;
    end else begin
      monitorStatusWord <= 16'h0;
      monitorStatusWord[egps_pkg::MON_DONE_BIT] <= inPosition_ff;
      monitorStatusWord[egps_pkg::MON_REACHED_BIT] <= (speedRef_ff == targetRef);
      monitorStatusWord[egps_pkg::MON_BLOCKED_BIT] <= pulseBlocked_ff;
      monitorStatusWord[egps_pkg::MON_ALT_A_BIT] <= selEnable ? presetActive : selFirst_ff;
      monitorStatusWord[egps_pkg::MON_ALT_B_BIT] <= selEnable ? dirReverse_ff : selSecond_ff;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence seqLeavePreset;
    presetActive && (speedRef_ff != 16'sh0) ##1 pulseMode;
  endsequence

  chk_gear_floor: assert property ((gearRatioNumerator_ff != 16'h0) &&
    (gearRatioDenominator_ff != 16'h0))
    else $error("gear term reached zero");
  chk_speed_clamp: assert property (presetSpeedThree_ff <= egps_pkg::MAX_SPEED_RPM &&
    presetSpeedOne_ff <= egps_pkg::MAX_SPEED_RPM)
    else $error("preset speed above maximum");
  chk_time_clamp: assert property (rampUpTime_ff <= egps_pkg::RAMP_TIME_MAX &&
    rampDownTime_ff <= egps_pkg::RAMP_TIME_MAX)
    else $error("ramp time above range");
  chk_select_latency: assert property ($changed(speedSelectFirst) |->
    ##[1:SEL_BOUND] (selFirst_ff == $past(speedSelectFirst)))
    else $error("select change not recognised in time");
  chk_pi_select: assert property (!selEnable && $stable(selEnable) |=>
    piSelect == $past(dirReverse_ff))
    else $error("PI select does not follow direction input");
  chk_reverse_sign: assert property (presetActive && dirReverse_ff &&
    (rampUpTime_ff == 16'h0) && (rampDownTime_ff == 16'h0) |=> speedRef_ff <= 16'sh0)
    else $error("reverse direction gave positive speed");
  chk_inhibit_ignored: assert property (selEnable && pulseMode && refPulse &&
    pulseInhibit && !pulseBlocked_ff && !setBlock |-> gearInPulse)
    else $error("inhibit input blocked pulses in selection mode");
  // The flag lands one clock after the mode edge, so the edge cycle relies on setBlock
  chk_block_hold: assert property (seqLeavePreset |->
    (!gearInPulse && setBlock) ##1 (pulseBlocked_ff && !gearInPulse))
    else $error("pulses accepted before positioning done");
  chk_ramp_slope: assert property (presetActive && $past(presetActive) &&
    $past(rampTime) != 16'h0 |-> (speedRef_ff - $past(speedRef_ff) <= 16'sh1) &&
    ($past(speedRef_ff) - speedRef_ff <= 16'sh1))
    else $error("ramp stepped more than one r/min per clock");
  chk_pulse_no_ramp: assert property (pulseMode |=> speedRef_ff == 16'sh0)
    else $error("speed reference ramping in pulse mode");
  chk_monitor_bits: assert property (selEnable && $stable(selEnable) |=>
    monitorStatusWord[egps_pkg::MON_ALT_B_BIT] == $past(dirReverse_ff))
    else $error("monitor bit 8 meaning wrong");
endmodule : egps_speed_gear

`default_nettype wire

// ===== include/egps_pkg.sv
// Purpose: Shared constants for the electronic gear and preset speed block
// Assumes: 40 MHz clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned words

// ****************************************************************
// Package
// ****************************************************************
package egps_pkg;
  // Clock and timing
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned RAMP_REF_MS = 1;
  localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000 * RAMP_REF_MS;
  localparam int unsigned SEL_LATENCY_MS = 6;
  localparam int unsigned SEL_LATENCY_CYCLES = CLOCK_HZ / 1000 * SEL_LATENCY_MS;

  // Register byte offsets
  localparam logic [7:0] OFS_GEAR_NUM = 8'h00;
  localparam logic [7:0] OFS_GEAR_DEN = 8'h04;
  localparam logic [7:0] OFS_SPEED_ONE = 8'h08;
  localparam logic [7:0] OFS_SPEED_TWO = 8'h0c;
  localparam logic [7:0] OFS_SPEED_THREE = 8'h10;
  localparam logic [7:0] OFS_RAMP_UP = 8'h14;
  localparam logic [7:0] OFS_RAMP_DOWN = 8'h18;
  localparam logic [7:0] OFS_FUNC_SWITCH = 8'h1c;
  localparam logic [7:0] OFS_MONITOR = 8'h20;
  localparam logic [7:0] OFS_SPEED_REF = 8'h24;

  // Reset values
  localparam logic [15:0] RST_GEAR = 16'h0001;
  localparam logic [15:0] RST_SPEED_ONE = 16'h0064;
  localparam logic [15:0] RST_SPEED_TWO = 16'h00c8;
  localparam logic [15:0] RST_SPEED_THREE = 16'h012c;
  localparam logic [15:0] RST_RAMP = 16'h0000;
  localparam logic [15:0] RST_FUNC_SWITCH = 16'h0000;

  // Limits
  localparam logic [15:0] GEAR_MIN = 16'h0001;
  localparam logic [15:0] MAX_SPEED_RPM = 16'h1194;
  localparam logic [15:0] RAMP_TIME_MAX = 16'h2710;

  // Field positions
  localparam int unsigned FSW_SPEED_SEL_BIT = 2;
  localparam int unsigned FSW_PULSE_REF_BIT = 15;
  localparam int unsigned MON_DONE_BIT = 0;
  localparam int unsigned MON_REACHED_BIT = 1;
  localparam int unsigned MON_BLOCKED_BIT = 2;
  localparam int unsigned MON_ALT_A_BIT = 7;
  localparam int unsigned MON_ALT_B_BIT = 8;
endpackage : egps_pkg

// ===== verilog/egps_gear_scaler.sv
// Purpose: Scales reference pulses by numerator over denominator
// Assumes: Numerator and denominator never zero
// Notes: At most one output pulse per clock; input rate times ratio must stay below it
`timescale 1ns/1ps
`default_nettype none

module egps_gear_scaler (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Input pulses
  input wire logic inPulse,
  input wire logic inDir,
  // Ratio
  input wire logic [15:0] numerator,
  input wire logic [15:0] denominator,
  // Scaled pulses
  output logic outPulse,
  output logic outDir
);
  // ****************************************************************
  // Accumulator
  // ****************************************************************
  logic signed [31:0] acc_ff;
  logic signed [31:0] nxt_acc;
  logic signed [31:0] numS;
  logic signed [31:0] denS;
  logic drainUp;
  logic drainDown;

  assign numS = signed'({16'h0000, numerator});
  assign denS = signed'({16'h0000, denominator});
  assign drainUp = acc_ff >= denS;
  assign drainDown = acc_ff <= -denS;

  // Remainder stays in the accumulator so fractions never get lost
  always_comb begin
    nxt_acc = acc_ff;
    if (inPulse) begin
      nxt_acc = inDir ? nxt_acc - numS : nxt_acc + numS;
    end
    if (drainUp) begin
      nxt_acc = nxt_acc - denS;
    end else if (drainDown) begin
      nxt_acc = nxt_acc + denS;
    end
  end

  // Accumulator update
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= 32'sh0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // Output pulse, reverse when the accumulator went negative
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outPulse <= 1'b0;
      outDir <= 1'b0;
    end else begin
      outPulse <= drainUp | drainDown;
      outDir <= drainDown & ~drainUp;
    end
  end

  chk_gear_emit: assert property (@(posedge clock) disable iff (!rst_n)
    (acc_ff >= denS) |=> (outPulse && !outDir))
    else $error("gear scaler missed a forward output pulse");
endmodule : egps_gear_scaler

`default_nettype wire

// ===== tb/egps_host_model.sv
// Purpose: Host controller model driving contacts and reference pulses
// Assumes: Bench commands change right after a rising clock edge
// Notes: One pulse every other clock keeps gear output under one per clock
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host model
// ****************************************
module egps_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench commands
  input wire logic [1:0] reqSel,
  input wire logic reqDir,
  input wire logic reqGo,
  input wire logic [7:0] reqCount,
  // Device feedback
  input wire logic positioningDone,
  // Contacts and pulses
  output logic speedSelectFirst,
  output logic speedSelectSecond,
  output logic directionOrPiSelect,
  output logic refPulse,
  output logic refPulseDir
);
  logic [7:0] left_ff;
  logic pulse_ff;
  // Contacts are plain levels
  assign {speedSelectFirst, speedSelectSecond} = reqSel;
  assign directionOrPiSelect = reqDir;
  assign refPulseDir = reqDir;
  assign refPulse = pulse_ff;
  // A burst waits for positioning done, so a late done stalls the host
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 8'h00;
      pulse_ff <= 1'b0;
    end else if (reqGo) begin
      left_ff <= reqCount;
      pulse_ff <= 1'b0;
    end else if (left_ff != 8'h00 && positioningDone && !pulse_ff) begin
      left_ff <= left_ff - 8'h01;
      pulse_ff <= 1'b1;
    end else begin
      pulse_ff <= 1'b0;
    end
  end
endmodule : egps_host_model
`default_nettype wire

// ===== tb/egps_speed_gear_tb.sv
// Purpose: Self-checking bench for the gear and preset speed block
// Assumes: Zero wait APB, short millisecond count for ramps
// Notes: Host model supplies contacts and pulses
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module egps_speed_gear_tb;
  localparam int CPM = 4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, rerr;
  logic pulseInhibit = 1'b0;
  logic inPosition = 1'b0;
  logic reqDir = 1'b0;
  logic reqGo = 1'b0;
  logic [1:0] reqSel = 2'h0;
  logic [7:0] reqCount = 8'h00;
  logic selA, selB, dirPi, refPulse, refPulseDir, gearPulse, gearPulseDir;
  logic presetActive, piSelect, fwdLim, revLim, positioningDone;
  logic signed [15:0] speedRef;
  logic [15:0] monitorStatusWord, expSpd;
  logic [15:0] rstVal [7] = '{16'h0001, 16'h0001, 16'h0064, 16'h00c8, 16'h012c,
                              16'h0000, 16'h0000};
  logic [1:0] codes [3] = '{2'b01, 2'b11, 2'b10};
  logic [15:0] spd [3] = '{16'h0064, 16'h00c8, 16'h012c};
  int badCount = 0;
  int numChecks = 0;
  int gearCount = 0;
  int gearRevCount = 0;

  always #12.5 clock = ~clock;

  egps_speed_gear #(.CYCLES_PER_MS(CPM)) i_dut (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .directionOrPiSelect(dirPi), .speedSelectFirst(selA), .speedSelectSecond(selB),
    .pulseInhibit(pulseInhibit), .refPulse(refPulse), .refPulseDir(refPulseDir),
    .inPosition(inPosition), .gearPulse(gearPulse), .gearPulseDir(gearPulseDir),
    .speedRef(speedRef), .presetActive(presetActive), .piSelect(piSelect),
    .fwdCurrentLimit(fwdLim), .revCurrentLimit(revLim),
    .positioningDone(positioningDone), .monitorStatusWord(monitorStatusWord));

  egps_host_model i_host (.clock(clock), .rst_n(rst_n), .reqSel(reqSel),
    .reqDir(reqDir), .reqGo(reqGo), .reqCount(reqCount),
    .positioningDone(positioningDone), .speedSelectFirst(selA),
    .speedSelectSecond(selB), .directionOrPiSelect(dirPi), .refPulse(refPulse),
    .refPulseDir(refPulseDir));

  // Count scaled pulses as the design emits them
  always @(posedge clock) if (gearPulse === 1'b1) gearCount++;
  // Reverse share of the scaled pulses, so the direction output is checked too
  always @(posedge clock) if (gearPulse === 1'b1 && gearPulseDir === 1'b1) gearRevCount++;

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitCyc

  task automatic go(input logic [7:0] n);
    reqCount <= n;
    reqGo <= 1'b1;
    @(posedge clock);
    reqGo <= 1'b0;
  endtask : go

  task automatic endSim();
    $display("checks %0d errors %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : endSim

  // Watchdog well beyond the expected run of about 1300 cycles
  initial begin
    waitCyc(6000);
    badCount++;
    endSim();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    waitCyc(10);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rdata, {16'h0000, rstVal[i]});
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({rerr, rdata[30:0]}, 32'h80000000);
    apb(1'b1, egps_pkg::OFS_GEAR_NUM, 32'h0);
    apb(1'b0, egps_pkg::OFS_GEAR_NUM, 32'h0);
    chk(rdata, 32'h1);
    // Standard meanings with selection off
    reqSel <= 2'b10;
    reqDir <= 1'b1;
    waitCyc(4);
    chk({piSelect, fwdLim, revLim}, 3'b110);
    apb(1'b0, egps_pkg::OFS_MONITOR, 32'h0);
    chk(rdata[8:7], 2'b01);
    // Ratio 3/2: four pulses must give six, remainder carried
    apb(1'b1, egps_pkg::OFS_GEAR_NUM, 32'h3);
    apb(1'b1, egps_pkg::OFS_GEAR_DEN, 32'h2);
    reqSel <= 2'b00;
    reqDir <= 1'b0;
    inPosition <= 1'b1;
    waitCyc(4);
    go(8'h04);
    waitCyc(30);
    chk(gearCount, 6);
    chk(gearRevCount, 0);
    pulseInhibit <= 1'b1;
    go(8'h02);
    waitCyc(20);
    chk(gearCount, 6);
    // Selection on, times zero, every speed code and direction
    apb(1'b1, egps_pkg::OFS_FUNC_SWITCH, 32'h8004);
    for (int i = 0; i < 6; i++) begin
      reqSel <= codes[i % 3];
      reqDir <= (i >= 3);
      expSpd = (i >= 3) ? 16'h0000 - spd[i % 3] : spd[i % 3];
      waitCyc(3);
      chk({16'h0000, speedRef}, {16'h0000, expSpd});
      chk(presetActive, 1'b1);
    end
    apb(1'b0, egps_pkg::OFS_MONITOR, 32'h0);
    chk(rdata[8:7], 2'b11);
    // Pulse mode with inhibit high: pulses still pass
    reqSel <= 2'b00;
    waitCyc(4);
    go(8'h02);
    waitCyc(20);
    chk(gearCount, 9);
    chk(gearRevCount, 3);
    // Leave preset while turning: blocked until in position
    reqSel <= 2'b01;
    waitCyc(3);
    inPosition <= 1'b0;
    reqSel <= 2'b00;
    go(8'h02);
    waitCyc(20);
    chk(gearCount, 9);
    inPosition <= 1'b1;
    waitCyc(20);
    // First burst pulse left while done was still high and hit the block; one remains
    chk(gearCount, 10);
    chk(gearRevCount, 4);
    // Ramps: 10000 ms to 4500 r/min is 40000 cycles at this count
    reqDir <= 1'b0;
    apb(1'b1, egps_pkg::OFS_RAMP_UP, 32'h2710);
    apb(1'b1, egps_pkg::OFS_RAMP_DOWN, 32'h2710);
    // Pulse reference off, so both selects off means stop and the ramp runs down
    apb(1'b1, egps_pkg::OFS_FUNC_SWITCH, 32'h0004);
    reqSel <= 2'b01;
    waitCyc(100);
    chk({31'h0, speedRef >= 16'sd8 && speedRef <= 16'sd13}, 32'h1);
    waitCyc(900);
    chk({16'h0000, speedRef}, 32'h64);
    reqSel <= 2'b00;
    waitCyc(100);
    chk({31'h0, speedRef >= 16'sd87 && speedRef <= 16'sd92}, 32'h1);
    endSim();
  end
endmodule : egps_speed_gear_tb
`default_nettype wire
